// File: fdh_pkg.sv
// Shared constants and types for the filter data handshake link.
// Assumes one 100 MHz clock shared by both ends and an active-low async reset.
`default_nettype none
package fdh_pkg;
	localparam int unsigned FDH_NCH = 2;
	localparam int unsigned FDH_SAMPLE_BITS = 13;
	localparam int unsigned FDH_OVL_BITS = 2;
	localparam int unsigned FDH_FRAME_BITS = 1 + FDH_OVL_BITS + FDH_SAMPLE_BITS;
	// Capture starts on the fourth clock after the request falls
	localparam int unsigned FDH_CAPTURE_DELAY = 4;
	// Converter drives first bit three clocks after the request
	localparam int unsigned FDH_SEND_DELAY = 3;
	// Grant spacing must outlast the filter's grant-to-release latency
	localparam int unsigned FDH_GRANT_GAP = 6;
	localparam logic [3:0] FDH_CMD_READ_STATUS = 4'h0;
	localparam logic [3:0] FDH_CMD_DMA_REG0 = 4'h1;
	localparam logic [3:0] FDH_CMD_DMA_REG1 = 4'h2;
	localparam logic [3:0] FDH_CMD_WRITE_COMMAND = 4'h3;
	localparam int unsigned FDH_RUN_BIT = 2;
	localparam logic [7:0] FDH_CMDREG_RESET = 8'h00;
	localparam logic [15:0] FDH_MIX_CONST = 16'h0fff;
	// Controller register map
	localparam logic [3:0] FDH_A_CTRL = 4'h0;
	localparam logic [3:0] FDH_A_COUNT1 = 4'h1;
	localparam logic [3:0] FDH_A_COUNT2 = 4'h2;
	localparam logic [3:0] FDH_A_FLAGS = 4'h3;
	localparam logic [3:0] FDH_A_HOSTCMD = 4'h4;
	localparam logic [3:0] FDH_A_HOSTSTAT = 4'h5;
	typedef enum logic [2:0] {
		FDH_REQ_IDLE = 3'b001,
		FDH_REQ_WAIT1 = 3'b010,
		FDH_REQ_WAIT2 = 3'b100
	} fdh_req_state_type;
endpackage
`default_nettype wire

// File: fdh_if.sv
// Interface joining the filter end and the controller end.
// Assumes both ends on the same clock; no tristate pins.
`default_nettype none
interface fdh_if;
	logic [1:0] output_request_n;
	logic [1:0] output_grant_n;
	logic [1:0] output_halt;
	logic [1:0] mix_source_select;
	logic [2:0] block_full;
	logic sample_request_n;
	logic [1:0] adc_serial_in;
	logic [15:0] lo_inphase_word;
	logic filter_cmd_ack_n;
	logic buffered_write_n;
	logic buffered_lower_strobe_n;
	logic buffered_upper_strobe_n;
	logic buffered_reset_n;
	logic [3:0] buffered_addr_low_n;
	logic [15:0] bus_wdata;
	logic [15:0] bus_rdata;
	logic filter_master_sync;
	logic diag_run_halt;
	modport filter (
		output output_request_n, block_full, sample_request_n, filter_cmd_ack_n,
		output bus_rdata, filter_master_sync, diag_run_halt,
		input output_grant_n, output_halt, mix_source_select, adc_serial_in,
		input lo_inphase_word, buffered_write_n, buffered_lower_strobe_n,
		input buffered_upper_strobe_n, buffered_reset_n, buffered_addr_low_n, bus_wdata
	);
	modport ctrl (
		input output_request_n, block_full, sample_request_n, filter_cmd_ack_n,
		input bus_rdata, filter_master_sync, diag_run_halt,
		output output_grant_n, output_halt, mix_source_select, adc_serial_in,
		output lo_inphase_word, buffered_write_n, buffered_lower_strobe_n,
		output buffered_upper_strobe_n, buffered_reset_n, buffered_addr_low_n, bus_wdata
	);
endinterface
`default_nettype wire

// File: fdh_chan.sv
// One filter channel: serial capture, mixing select and output request.
// Assumes link inputs already synchronised by the instantiating end.
`default_nettype none
module fdh_chan #(
	parameter int unsigned OUT_WORDS = 4
) (
	input wire logic clk, // Clock
	input wire logic nrst, // Async reset, active low
	input wire logic sample_go, // Shared request start pulse
	input wire logic serial_in, // Converter serial bit
	input wire logic grant_n, // Synchronised grant
	input wire logic halt, // Synchronised halt
	input wire logic mix_sel, // Synchronised mix select
	input wire logic zoom, // Complex transfer mode
	input wire logic [15:0] lo_word, // Oscillator word
	output logic request_n, // Output request
	output logic frame_done, // Frame captured pulse
	output logic [15:0] mixed, // Last mixed result
	output logic [1:0] ovl // Overload bits
);
	logic [4:0] bit_cnt_r;
	logic [2:0] dly_r;
	logic cap_r;
	logic [fdh_pkg::FDH_FRAME_BITS-1:0] shreg_r;
	logic grant_d_r;
	fdh_pkg::fdh_req_state_type st_r, st_nxt;
	wire grant_fall = grant_d_r & ~grant_n;
	wire [15:0] mix_in = mix_sel ? lo_word : fdh_pkg::FDH_MIX_CONST;
	wire last_bit = cap_r && bit_cnt_r == 5'(fdh_pkg::FDH_FRAME_BITS - 1);
	// Valid bit is sent first, so LSB-first shifting leaves it at bit 0
	wire frame_valid = shreg_r[0];

	// ------------------------------------------------------------
	// Serial capture
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dly_r <= 3'h0;
			cap_r <= 1'b0;
			bit_cnt_r <= 5'h0;
			shreg_r <= '0;
			frame_done <= 1'b0;
		end else begin
			frame_done <= last_bit;
			if (sample_go) begin
				// Two synchroniser stages sit in front of serial_in
				dly_r <= 3'(fdh_pkg::FDH_CAPTURE_DELAY); // R10
			end else if (dly_r != 3'h0) begin
				dly_r <= dly_r - 3'h1;
			end
			if (dly_r == 3'h1) begin
				cap_r <= 1'b1;
				bit_cnt_r <= 5'h0;
			end else if (last_bit) begin
				cap_r <= 1'b0;
			end else if (cap_r) begin
				bit_cnt_r <= bit_cnt_r + 5'h1;
			end
			if (cap_r) begin
				shreg_r <= {serial_in, shreg_r[fdh_pkg::FDH_FRAME_BITS-1:1]}; // R12
			end
		end
	end

	// ------------------------------------------------------------
	// Output request handshake
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			fdh_pkg::FDH_REQ_IDLE: if (frame_done && frame_valid && !halt) begin
				st_nxt = fdh_pkg::FDH_REQ_WAIT1; // R1 R7
			end
			fdh_pkg::FDH_REQ_WAIT1: if (grant_fall) st_nxt = zoom ? fdh_pkg::FDH_REQ_WAIT2
				: fdh_pkg::FDH_REQ_IDLE; // R2
			fdh_pkg::FDH_REQ_WAIT2: if (grant_fall) st_nxt = fdh_pkg::FDH_REQ_IDLE; // R3
			default: st_nxt = fdh_pkg::FDH_REQ_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= fdh_pkg::FDH_REQ_IDLE;
			grant_d_r <= 1'b1;
			request_n <= 1'b1;
			mixed <= 16'h0000;
			ovl <= 2'h0;
		end else begin
			st_r <= st_nxt;
			grant_d_r <= grant_n;
			request_n <= (st_nxt == fdh_pkg::FDH_REQ_IDLE);
			if (frame_done && frame_valid) begin
				// Scaled product kept simple: sample times mix word upper bits
				mixed <= 16'(shreg_r[fdh_pkg::FDH_FRAME_BITS-1:3] * mix_in[15:13]); // R8
				ovl <= shreg_r[2:1];
			end
		end
	end
endmodule
`default_nettype wire

// File: fdh_filter.sv
// Filter-board end of the handshake link, two channels.
// Assumes the controller end drives all link inputs; resets from buffered reset.
// --------------------------------------------------------------------------
// Notes on behaviour
// R1 - Ready result pulls channel request low
// R2 - Real transfer: release request at grant
// R3 - Zoom: release request after second grant
// R4 - Controller frames transfers by request line
// R5 - One grant pulse per written sample
// R6 - Controller flags rising block-full edges
// R7 - Halt high disables channel output section
// R8 - Mix select picks oscillator or constant
// R9 - Real-mode oscillator cosine means one
// R10 - Request sample, capture from fourth clock
// R11 - Converter shifts three clocks after request
// R12 - Frame: valid, overload bits, LSB-first sample
// R13 - Acknowledge low on completed status/DMA command
// R14 - Controller returns host acknowledge afterwards
// R15 - Lower strobe qualifies command decoding
// R16 - Write line decodes and picks direction
// R17 - Controller buffers upper strobe to filter
// R18 - Controller buffers reset; filter resets
// R19 - Diagnostic line mirrors command bit two
// R20 - Four low address lines decode commands
// R21 - Sync pulse on completed status/DMA command
// R22 - Samples and oscillator on shared clock
// R23 - Channels duplicated and independent
// --------------------------------------------------------------------------
//
// Local design decisions: the register offsets and the plain strobed port.
`default_nettype none
module fdh_filter #(
	parameter int unsigned SAMPLE_PERIOD = 64,
	parameter int unsigned BLOCK_LEN = 16
) (
	input wire logic clk, // Sample-side clock
	fdh_if.filter lk, // Link to controller
	input wire logic zoom, // Complex transfer mode
	output logic [15:0] ch1_result, // Channel 1 mixed result
	output logic [15:0] ch2_result // Channel 2 mixed result
);
	logic rst_s1_r, nrst;
	logic [1:0] grant_s1_r, grant_s2_r, halt_s1_r, halt_s2_r, sel_s1_r, sel_s2_r;
	logic [1:0] din_s1_r, din_s2_r;
	logic [1:0] grant_s3_r, dma_wr;
	logic [3:0] addr_s1_r, addr_s2_r;
	logic wr_s1_r, wr_s2_r, lds_s1_r, lds_s2_r, lds_d_r;
	logic [7:0] cmd_r;
	logic [15:0] status_r;
	logic [7:0] per_cnt_r;
	logic sample_go_r;
	logic [1:0] frame_done;
	logic [1:0] req_n;
	logic [15:0] mixed [2];
	logic [1:0] ovl [2];
	logic [7:0] blk_cnt_r [2];
	logic [2:0] block_full_r;
	logic [15:0] lo_word_r;
	logic [7:0] frm_cnt_r;

	// Block position counters wrap after BLOCK_LEN entries
	function automatic logic [7:0] blk_next(input logic [7:0] v);
		return (v == 8'(BLOCK_LEN - 1)) ? 8'h00 : v + 8'h01;
	endfunction

	// ------------------------------------------------------------
	// Reset and input synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge lk.buffered_reset_n) begin
		if (!lk.buffered_reset_n) begin
			rst_s1_r <= 1'b0;
			nrst <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			nrst <= rst_s1_r; // R18
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			{grant_s1_r, grant_s2_r, grant_s3_r} <= 6'h3f;
			{halt_s1_r, halt_s2_r} <= 4'hf;
			{sel_s1_r, sel_s2_r} <= 4'h0;
			{din_s1_r, din_s2_r} <= 4'h0;
			{addr_s1_r, addr_s2_r} <= 8'hff;
			{wr_s1_r, wr_s2_r, lds_s1_r, lds_s2_r} <= 4'hf;
			lo_word_r <= 16'h0000;
		end else begin
			grant_s1_r <= lk.output_grant_n;
			grant_s2_r <= grant_s1_r;
			grant_s3_r <= grant_s2_r;
			halt_s1_r <= lk.output_halt;
			halt_s2_r <= halt_s1_r;
			sel_s1_r <= lk.mix_source_select;
			sel_s2_r <= sel_s1_r;
			din_s1_r <= lk.adc_serial_in;
			din_s2_r <= din_s1_r;
			addr_s1_r <= lk.buffered_addr_low_n;
			addr_s2_r <= addr_s1_r;
			wr_s1_r <= lk.buffered_write_n;
			wr_s2_r <= wr_s1_r;
			lds_s1_r <= lk.buffered_lower_strobe_n;
			lds_s2_r <= lds_s1_r;
			lo_word_r <= lk.lo_inphase_word; // R22
		end
	end

	// ------------------------------------------------------------
	// Sample request pacing, shared by both channels
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			per_cnt_r <= 8'h00;
			sample_go_r <= 1'b0;
			lk.sample_request_n <= 1'b1;
		end else begin
			per_cnt_r <= (per_cnt_r == 8'(SAMPLE_PERIOD - 1)) ? 8'h00 : per_cnt_r + 8'h01;
			sample_go_r <= (per_cnt_r == 8'h00) && cmd_r[fdh_pkg::FDH_RUN_BIT];
			lk.sample_request_n <= !((per_cnt_r == 8'h00) && cmd_r[fdh_pkg::FDH_RUN_BIT]); // R10
		end
	end

	// Capture timing in each channel allows for the serial data synchroniser
	for (genvar c = 0; c < 2; c++) begin : g_ch
		fdh_chan u_chan (
			.clk(clk),
			.nrst(nrst),
			.sample_go(sample_go_r),
			.serial_in(din_s2_r[c]),
			.grant_n(grant_s2_r[c]),
			.halt(halt_s2_r[c]),
			.mix_sel(sel_s2_r[c]),
			.zoom(zoom),
			.lo_word(lo_word_r),
			.request_n(req_n[c]),
			.frame_done(frame_done[c]),
			.mixed(mixed[c]),
			.ovl(ovl[c])
		); // R23

		// Count grant pulses to mark full blocks
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				blk_cnt_r[c] <= 8'h00;
			end else if (dma_wr[c]) begin
				blk_cnt_r[c] <= lk.bus_wdata[7:0]; // R13
			end else if (grant_s3_r[c] && !grant_s2_r[c]) begin
				blk_cnt_r[c] <= blk_next(blk_cnt_r[c]); // R5
			end
		end
	end

	// Unfiltered block fills only while channel 1 output is enabled
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			frm_cnt_r <= 8'h00;
		end else if (frame_done[0] && !halt_s2_r[0]) begin
			frm_cnt_r <= blk_next(frm_cnt_r); // R7
		end
	end

	// ------------------------------------------------------------
	// Command decode and acknowledge
	// ------------------------------------------------------------
	wire lds_fall = lds_d_r & ~lds_s2_r; // R15
	wire [3:0] cmd_addr = ~addr_s2_r; // R20
	wire is_write = ~wr_s2_r; // R16
	wire ack_cmd = lds_fall && (cmd_addr == fdh_pkg::FDH_CMD_READ_STATUS ||
		cmd_addr == fdh_pkg::FDH_CMD_DMA_REG0 || cmd_addr == fdh_pkg::FDH_CMD_DMA_REG1);
	wire cmd_wr = lds_fall && is_write && cmd_addr == fdh_pkg::FDH_CMD_WRITE_COMMAND;
	assign dma_wr = {2{lds_fall && is_write}} & {cmd_addr == fdh_pkg::FDH_CMD_DMA_REG1,
		cmd_addr == fdh_pkg::FDH_CMD_DMA_REG0}; // R16

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lds_d_r <= 1'b1;
			cmd_r <= fdh_pkg::FDH_CMDREG_RESET;
			status_r <= 16'h0000;
			lk.filter_cmd_ack_n <= 1'b1;
			lk.filter_master_sync <= 1'b0;
			lk.bus_rdata <= 16'h0000;
			lk.diag_run_halt <= 1'b0;
			lk.output_request_n <= 2'h3;
			block_full_r <= 3'h0;
			ch1_result <= 16'h0000;
			ch2_result <= 16'h0000;
		end else begin
			lds_d_r <= lds_s2_r;
			if (cmd_wr) begin
				cmd_r <= lk.bus_wdata[7:0];
			end
			status_r <= {8'h00, cmd_r[3:0], ovl[1], ovl[0]};
			if (ack_cmd && !is_write) begin
				lk.bus_rdata <= (cmd_addr == fdh_pkg::FDH_CMD_READ_STATUS) ? status_r
					: {8'h00, blk_cnt_r[cmd_addr == fdh_pkg::FDH_CMD_DMA_REG1]};
			end
			// Ack stays low while the strobe is held, then releases
			if (ack_cmd) begin
				lk.filter_cmd_ack_n <= 1'b0; // R13
			end else if (lds_s2_r) begin
				lk.filter_cmd_ack_n <= 1'b1;
			end
			lk.filter_master_sync <= ack_cmd; // R21
			lk.diag_run_halt <= cmd_r[fdh_pkg::FDH_RUN_BIT]; // R19
			lk.output_request_n <= req_n;
			block_full_r[0] <= (blk_cnt_r[0] == 8'(BLOCK_LEN - 1));
			block_full_r[1] <= (blk_cnt_r[1] == 8'(BLOCK_LEN - 1));
			block_full_r[2] <= (frm_cnt_r == 8'(BLOCK_LEN - 1));
			ch1_result <= mixed[0];
			ch2_result <= mixed[1];
		end
	end
	assign lk.block_full = block_full_r;
endmodule
`default_nettype wire

// File: fdh_ctrl.sv
// Controller and converter end: grants, halts, selects, host port, serial source.
// Assumes the filter end on the same clock; host port is a plain strobe bus.
`default_nettype none
module fdh_ctrl (
	input wire logic clk, // Clock
	input wire logic nrst, // Async reset, active low
	fdh_if.ctrl lk, // Link to filter
	input wire logic [3:0] addr, // Register address
	input wire logic [15:0] wdata, // Write data
	input wire logic wr, // Write strobe
	input wire logic rd, // Read strobe
	input wire logic [12:0] adc_sample, // Sample to send on both channels
	output logic [15:0] rdata, // Read data
	output logic host_transfer_ack_n // Host ack, one cycle low
);
	logic [7:0] ctrl_r;
	logic [15:0] cnt_r [2];
	logic [2:0] flags_r, bf_d_r;
	logic [1:0] req_d_r;
	logic [4:0] sdly_r;
	logic [fdh_pkg::FDH_FRAME_BITS-1:0] sh_r;
	logic [15:0] hstat_r;
	logic hcmd_busy_r, ack_d_r, dreq_d_r;
	logic [2:0] gap_r [2];
	// Spacing lets a real transfer release before a second grant could go out
	wire [1:0] grant_go = ~lk.output_request_n & lk.output_grant_n & ~ctrl_r[7:6]
		& {gap_r[1] == 3'h0, gap_r[0] == 3'h0}; // R5
	wire sreq_fall = dreq_d_r & ~lk.sample_request_n;
	wire [2:0] bf_rise = lk.block_full & ~bf_d_r; // R6

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_r <= 8'h00;
			flags_r <= 3'h0;
			bf_d_r <= 3'h0;
			req_d_r <= 2'h3;
			cnt_r[0] <= 16'h0000;
			cnt_r[1] <= 16'h0000;
			gap_r[0] <= 3'h0;
			gap_r[1] <= 3'h0;
			lk.output_grant_n <= 2'h3;
			lk.output_halt <= 2'h3;
			lk.mix_source_select <= 2'h0;
			lk.buffered_reset_n <= 1'b0;
			lk.buffered_write_n <= 1'b1;
			lk.buffered_lower_strobe_n <= 1'b1;
			lk.buffered_upper_strobe_n <= 1'b1;
			lk.buffered_addr_low_n <= 4'hf;
			lk.bus_wdata <= 16'h0000;
			lk.lo_inphase_word <= fdh_pkg::FDH_MIX_CONST;
			lk.adc_serial_in <= 2'h0;
			rdata <= 16'h0000;
			host_transfer_ack_n <= 1'b1;
			hcmd_busy_r <= 1'b0;
			hstat_r <= 16'h0000;
			ack_d_r <= 1'b1;
			dreq_d_r <= 1'b1;
			sdly_r <= 5'h0;
			sh_r <= '0;
		end else begin
			lk.buffered_reset_n <= 1'b1; // R18
			bf_d_r <= lk.block_full;
			req_d_r <= lk.output_request_n;
			ack_d_r <= lk.filter_cmd_ack_n;
			dreq_d_r <= lk.sample_request_n;
			flags_r <= (flags_r & ~((wr && addr == fdh_pkg::FDH_A_FLAGS) ? wdata[2:0] : 3'h0))
				| bf_rise;
			if (wr && addr == fdh_pkg::FDH_A_CTRL) ctrl_r <= wdata[7:0];
			lk.output_halt <= ~ctrl_r[1:0]; // R4
			lk.mix_source_select <= ctrl_r[3:2];
			lk.lo_inphase_word <= ctrl_r[4] ? {ctrl_r[7:5], 13'h0} : fdh_pkg::FDH_MIX_CONST; // R9 R22
			for (int c = 0; c < 2; c++) begin
				lk.output_grant_n[c] <= !grant_go[c];
				if (grant_go[c]) begin
					gap_r[c] <= 3'(fdh_pkg::FDH_GRANT_GAP);
				end else if (gap_r[c] != 3'h0) begin
					gap_r[c] <= gap_r[c] - 3'h1;
				end
				if (!lk.output_grant_n[c]) cnt_r[c] <= cnt_r[c] + 16'h0001; // R5
			end
			// Host command forwarded to filter pins
			if (wr && addr == fdh_pkg::FDH_A_HOSTCMD) begin
				lk.buffered_addr_low_n <= ~wdata[3:0];
				lk.buffered_write_n <= ~wdata[4];
				lk.bus_wdata <= {8'h00, wdata[15:8]};
				lk.buffered_lower_strobe_n <= 1'b0;
				lk.buffered_upper_strobe_n <= 1'b0; // R17
				hcmd_busy_r <= 1'b1;
			end else if (hcmd_busy_r && ack_d_r && !lk.filter_cmd_ack_n) begin
				lk.buffered_lower_strobe_n <= 1'b1;
				lk.buffered_upper_strobe_n <= 1'b1;
				hcmd_busy_r <= 1'b0;
				hstat_r <= lk.bus_rdata;
			end
			host_transfer_ack_n <= !(hcmd_busy_r && ack_d_r && !lk.filter_cmd_ack_n); // R14
			// Converter: first bit on the pin three clocks after the request.
			// Edge detect and output flop each take one of those clocks.
			if (sreq_fall) begin
				sdly_r <= 5'(fdh_pkg::FDH_SEND_DELAY - 2);
				sh_r <= {adc_sample, 2'b00, 1'b1};
			end else if (sdly_r != 5'h0) begin
				sdly_r <= sdly_r - 5'h1;
			end else begin
				sh_r <= {1'b0, sh_r[fdh_pkg::FDH_FRAME_BITS-1:1]};
			end
			lk.adc_serial_in <= (sdly_r == 5'h0) ? {2{sh_r[0]}} : 2'h0; // R11 R12
			rdata <= 16'h0000;
			if (rd) begin
				case (addr)
					fdh_pkg::FDH_A_CTRL: rdata <= {8'h00, ctrl_r};
					fdh_pkg::FDH_A_COUNT1: rdata <= cnt_r[0];
					fdh_pkg::FDH_A_COUNT2: rdata <= cnt_r[1];
					fdh_pkg::FDH_A_FLAGS: rdata <= {11'h0, ~req_d_r, flags_r};
					fdh_pkg::FDH_A_HOSTSTAT: rdata <= {hstat_r[14:0], hcmd_busy_r};
					default: rdata <= 16'h0000;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// File: fdh_props.sv
// Checker for the filter handshake link, placed beside the interface.
// Assumes one clock for both ends and the controller's active-low reset.
`default_nettype none
module fdh_props #(
	parameter int unsigned SAMPLE_PERIOD = 64
) (
	input wire logic clk, // Clock
	input wire logic nrst, // Reset, active low
	input wire logic zoom, // Complex transfer mode
	input wire logic [1:0] output_request_n, // Output requests
	input wire logic [1:0] output_grant_n, // Output grants
	input wire logic [1:0] output_halt, // Output halts
	input wire logic sample_request_n, // Sample request
	input wire logic [1:0] adc_serial_in, // Serial samples
	input wire logic filter_cmd_ack_n, // Command acknowledge
	input wire logic buffered_lower_strobe_n, // Lower strobe
	input wire logic [3:0] buffered_addr_low_n, // Command code, inverted
	input wire logic filter_master_sync, // Sync pulse
	input wire logic diag_run_halt // Run bit mirror
);
	// ----------------------------------------
	// Helper counters
	// ----------------------------------------
	logic [1:0][3:0] gcnt_r;
	logic [15:0] sp_cnt_r;
	logic sp_seen_r;
	wire logic cmd3 = (~buffered_addr_low_n) == fdh_pkg::FDH_CMD_WRITE_COMMAND;

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	// Grants counted only while the request is low, so a late grant is not credited
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gcnt_r <= '0;
			sp_cnt_r <= 16'h0;
			sp_seen_r <= 1'b0;
		end else begin
			for (int k = 0; k < 2; k++) begin
				gcnt_r[k] <= output_request_n[k] ? 4'h0 : gcnt_r[k] + {3'h0, !output_grant_n[k]};
			end
			sp_cnt_r <= sample_request_n ? sp_cnt_r + 16'h1 : 16'h0;
			sp_seen_r <= sp_seen_r | !sample_request_n;
		end
	end

	sequence s_frame_lead;
		##3 (adc_serial_in == 2'b11);
	endsequence
	sequence s_frame_twin;
		(adc_serial_in[0] == adc_serial_in[1]) [*8];
	endsequence

	chk_halt_no_req: assert property ($fell(output_request_n[0]) |->
		!(output_halt[0] && $past(output_halt[0], 8))) else $error("request while halted");
	chk_ch1_release: assert property ($rose(output_request_n[0]) && !output_halt[0] |->
		gcnt_r[0] >= (zoom ? 4'h2 : 4'h1)) else $error("ch1 released early");
	chk_ch2_release: assert property ($rose(output_request_n[1]) && !output_halt[1] |->
		gcnt_r[1] >= (zoom ? 4'h2 : 4'h1)) else $error("ch2 released early");
	chk_grant_pulse: assert property ($fell(output_grant_n[0]) |=> output_grant_n[0])
		else $error("grant not a pulse");
	chk_sreq_run: assert property (!sample_request_n |-> diag_run_halt ##1 sample_request_n)
		else $error("bad sample request");
	chk_sreq_period: assert property ($fell(sample_request_n) && sp_seen_r |->
		sp_cnt_r == SAMPLE_PERIOD - 1) else $error("sample period wrong");
	chk_frame_order: assert property ($fell(sample_request_n) |->
		s_frame_lead ##1 s_frame_twin) else $error("frame start wrong");
	chk_ack_follows: assert property ($fell(buffered_lower_strobe_n) && !cmd3 |->
		##[1:8] !filter_cmd_ack_n) else $error("no command ack");
	chk_ack_in_cmd: assert property ($fell(filter_cmd_ack_n) |->
		!buffered_lower_strobe_n && !cmd3) else $error("ack outside command");
	chk_sync_pulse: assert property (filter_master_sync |-> !cmd3 ##1 !filter_master_sync)
		else $error("bad sync pulse");
endmodule
`default_nettype wire

// File: tb_top.sv
// Testbench joining both link ends; drives the controller host port.
// Assumes fdh_pkg, fdh_if and both ends are compiled first.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned SP = 32;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic zoom = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [12:0] adc_sample = 13'h1a5b;
	logic [15:0] rdata;
	logic host_transfer_ack_n;
	logic [15:0] r1;
	logic [15:0] r2;
	int fail_count = 0;
	int checks = 0;
	int cyc = 0;
	logic [15:0] gseen [2] = '{16'h0, 16'h0};
	logic [1:0] gprev = 2'b11;
	logic [2:0] bprev = 3'h0;
	logic [2:0] brise = 3'h0;

	fdh_if lk ();
	fdh_ctrl i_fdh_ctrl (.clk(clk), .nrst(nrst), .lk(lk.ctrl), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .adc_sample(adc_sample), .rdata(rdata),
		.host_transfer_ack_n(host_transfer_ack_n));
	fdh_filter #(.SAMPLE_PERIOD(SP), .BLOCK_LEN(4)) i_fdh_filter (.clk(clk), .lk(lk.filter),
		.zoom(zoom), .ch1_result(r1), .ch2_result(r2));
	fdh_props #(.SAMPLE_PERIOD(SP)) i_fdh_props (.clk(clk), .nrst(nrst), .zoom(zoom),
		.output_request_n(lk.output_request_n), .output_grant_n(lk.output_grant_n),
		.output_halt(lk.output_halt), .sample_request_n(lk.sample_request_n),
		.adc_serial_in(lk.adc_serial_in), .filter_cmd_ack_n(lk.filter_cmd_ack_n),
		.buffered_lower_strobe_n(lk.buffered_lower_strobe_n),
		.buffered_addr_low_n(lk.buffered_addr_low_n),
		.filter_master_sync(lk.filter_master_sync), .diag_run_halt(lk.diag_run_halt));

	always #5 clk = ~clk;

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic stop_test();
		if (fail_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic host_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic host_rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	// Controller stays busy until the host ack, so every command waits for it
	task automatic filt_cmd(input logic [3:0] c, input logic w, input logic [7:0] d);
		int n;
		host_wr(fdh_pkg::FDH_A_HOSTCMD, {d, 3'h0, w, c});
		for (n = 0; n < 60 && host_transfer_ack_n !== 1'b0; n++)
			@(negedge clk);
		check({15'h0, host_transfer_ack_n}, 16'h0);
	endtask

	// Grant pulses and block-full rises seen on the wire; also the hang limit
	always @(negedge clk) begin
		cyc++;
		for (int k = 0; k < 2; k++)
			if (gprev[k] && !lk.output_grant_n[k])
				gseen[k]++;
		brise = brise | (lk.block_full & ~bprev);
		gprev = lk.output_grant_n;
		bprev = lk.block_full;
		if (cyc == 20000) begin
			fail_count++;
			stop_test();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [15:0] v;
		logic [12:0] b1;
		logic [12:0] b2;
		int n;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		repeat (6) @(posedge clk);
		#1;
		check({12'h0, lk.output_request_n, lk.output_halt}, 16'h000f);
		check({14'h0, lk.diag_run_halt, lk.filter_cmd_ack_n}, 16'h0001);
		for (logic [3:0] c = 4'h1; c <= 4'h2; c++) begin
			filt_cmd(c, 1'b1, {4'h0, c});
			filt_cmd(c, 1'b0, 8'h00);
			host_rd(fdh_pkg::FDH_A_HOSTSTAT, v);
			check({8'h0, v[8:1]}, {12'h0, c});
		end
		filt_cmd(fdh_pkg::FDH_CMD_READ_STATUS, 1'b0, 8'h00);
		host_rd(fdh_pkg::FDH_A_HOSTSTAT, v);
		check(v, 16'h0000);
		// Run both, channel 1 mixes the oscillator word, whose top bits are 001
		host_wr(fdh_pkg::FDH_A_CTRL, 16'h0037);
		repeat (4) @(posedge clk);
		#1;
		check({12'h0, lk.output_halt, lk.mix_source_select}, 16'h0001);
		// No ack comes for the command register write, so it goes last
		host_wr(fdh_pkg::FDH_A_HOSTCMD, {8'h04, 3'h0, 1'b1, fdh_pkg::FDH_CMD_WRITE_COMMAND});
		repeat (20) @(posedge clk);
		#1;
		check({15'h0, lk.diag_run_halt}, 16'h0001);
		for (n = 0; n < 200 && lk.sample_request_n !== 1'b0; n++)
			@(negedge clk);
		check({15'h0, lk.sample_request_n}, 16'h0);
		repeat (3) @(negedge clk);
		check({14'h0, lk.adc_serial_in}, 16'h0003);
		repeat (2) @(negedge clk);
		for (int i = 0; i < 13; i++) begin
			@(negedge clk);
			b1[i] = lk.adc_serial_in[0];
			b2[i] = lk.adc_serial_in[1];
		end
		check({3'h0, b1}, {3'h0, adc_sample});
		check({3'h0, b2}, {3'h0, adc_sample});
		repeat (12 * SP) @(posedge clk);
		#1;
		check(r1, {3'h0, adc_sample});
		check(r2, 16'h0000);
		host_wr(fdh_pkg::FDH_A_CTRL, 16'h0004);
		repeat (100) @(posedge clk);
		zoom <= 1'b1;
		host_wr(fdh_pkg::FDH_A_CTRL, 16'h0007);
		repeat (12 * SP) @(posedge clk);
		host_wr(fdh_pkg::FDH_A_CTRL, 16'h0004);
		repeat (100) @(posedge clk);
		#1;
		check({14'h0, lk.output_request_n}, 16'h0003);
		check({15'h0, gseen[0] == 16'h0}, 16'h0);
		host_rd(fdh_pkg::FDH_A_COUNT1, v);
		check(v, gseen[0]);
		host_rd(fdh_pkg::FDH_A_COUNT2, v);
		check(v, gseen[1]);
		host_rd(fdh_pkg::FDH_A_FLAGS, v);
		check({13'h0, v[2:0]}, {13'h0, brise});
		host_wr(fdh_pkg::FDH_A_FLAGS, 16'h0007);
		host_rd(fdh_pkg::FDH_A_FLAGS, v);
		check({13'h0, v[2:0]}, 16'h0);
		stop_test();
	end
endmodule
`default_nettype wire
